// ---- design/ibc_map.vh ----
// Register map, field positions and reset values of the collision-aware master
`ifndef IBC_MAP_VH
`define IBC_MAP_VH

`define IBC_OFS_CTRL      8'h00
`define IBC_OFS_STATUS    8'h04
`define IBC_OFS_RATE      8'h08
`define IBC_OFS_BUFFER    8'h0C
`define IBC_OFS_IRQ_STAT  8'h10
`define IBC_OFS_IRQ_MASK  8'h14

`define IBC_CTRL_START    0
`define IBC_CTRL_RSTART   1
`define IBC_CTRL_STOP     2
`define IBC_CTRL_ACK      3
`define IBC_CTRL_ACKDT    4

`define IBC_ST_FULL       0
`define IBC_ST_ACKSTAT    1
`define IBC_ST_START_SEEN 2
`define IBC_ST_STOP_SEEN  3
`define IBC_ST_BUSY       4

`define IBC_IRQ_COLL      0
`define IBC_IRQ_PORT      1

`define IBC_RATE_RST      7'h09
`define IBC_RESP_OKAY     2'h0
`define IBC_RESP_SLVERR   2'h2

`endif

// ---- design/ibc_bus_collision.v ----
// Two-wire master sequencer with arbitration loss detection and AXI4-Lite regs
//
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "ibc_map.vh"

module ibc_bus_collision (
    aclk,
    aresetn,
    s_axi_awaddr,
    s_axi_awvalid,
    s_axi_awready,
    s_axi_wdata,
    s_axi_wstrb,
    s_axi_wvalid,
    s_axi_wready,
    s_axi_bresp,
    s_axi_bvalid,
    s_axi_bready,
    s_axi_araddr,
    s_axi_arvalid,
    s_axi_arready,
    s_axi_rdata,
    s_axi_rresp,
    s_axi_rvalid,
    s_axi_rready,
    sda_i,
    sda_o,
    sda_oe,
    scl_i,
    scl_o,
    scl_oe,
    irq
);
    input  wire        aclk;
    input  wire        aresetn;
    input  wire [7:0]  s_axi_awaddr;
    input  wire        s_axi_awvalid;
    output reg         s_axi_awready;
    input  wire [31:0] s_axi_wdata;
    input  wire [3:0]  s_axi_wstrb;
    input  wire        s_axi_wvalid;
    output reg         s_axi_wready;
    output reg  [1:0]  s_axi_bresp;
    output reg         s_axi_bvalid;
    input  wire        s_axi_bready;
    input  wire [7:0]  s_axi_araddr;
    input  wire        s_axi_arvalid;
    output reg         s_axi_arready;
    output reg  [31:0] s_axi_rdata;
    output reg  [1:0]  s_axi_rresp;
    output reg         s_axi_rvalid;
    input  wire        s_axi_rready;
    input  wire        sda_i;
    output reg         sda_o;
    output reg         sda_oe;
    input  wire        scl_i;
    output reg         scl_o;
    output reg         scl_oe;
    output reg         irq;

    localparam [3:0] S_IDLE  = 4'h0;
    localparam [3:0] S_STC1  = 4'h1;
    localparam [3:0] S_STC2  = 4'h2;
    localparam [3:0] S_RSDA  = 4'h3;
    localparam [3:0] S_RSC1  = 4'h4;
    localparam [3:0] S_RSCW  = 4'h5;
    localparam [3:0] S_RSC2  = 4'h6;
    localparam [3:0] S_RSC3  = 4'h7;
    localparam [3:0] S_SPLO  = 4'h8;
    localparam [3:0] S_SPCW  = 4'h9;
    localparam [3:0] S_SPC1  = 4'hA;
    localparam [3:0] S_SPC2  = 4'hB;
    localparam [3:0] S_BLOW  = 4'hC;
    localparam [3:0] S_BSCW  = 4'hD;
    localparam [3:0] S_BHIG  = 4'hE;

    reg  [2:0]  sda_sync_r;
    reg  [2:0]  scl_sync_r;
    reg         sda_f_r;
    reg         scl_f_r;
    reg         sda_prev_r;
    reg  [3:0]  state_r;
    reg  [6:0]  brg_r;
    reg  [6:0]  rate_r;
    reg  [4:0]  ctrl_r;
    reg  [8:0]  shift_r;
    reg  [3:0]  bits_r;
    reg         ack_mode_r;
    reg         full_r;
    reg         ackstat_r;
    reg         start_seen_r;
    reg         stop_seen_r;
    reg  [1:0]  flags_r;
    reg  [1:0]  mask_r;

    wire        wr_go   = s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
                          !s_axi_bvalid;
    wire        rd_go   = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    wire        wr_lo   = wr_go && s_axi_wstrb[0];
    wire        brg_end = (brg_r == 7'h00);
    wire        idle    = (state_r == S_IDLE);
    wire        wr_map  = (s_axi_awaddr == `IBC_OFS_CTRL) ||
                          (s_axi_awaddr == `IBC_OFS_STATUS) ||
                          (s_axi_awaddr == `IBC_OFS_RATE) ||
                          (s_axi_awaddr == `IBC_OFS_BUFFER) ||
                          (s_axi_awaddr == `IBC_OFS_IRQ_STAT) ||
                          (s_axi_awaddr == `IBC_OFS_IRQ_MASK);
    // The released bit of a byte is the slave's acknowledge, not arbitration
    wire        chk_one = shift_r[8] && !(bits_r == 4'h1 && !ack_mode_r);

    // Filtered line levels only follow once the last two stages agree
    always @(posedge aclk) begin
        if (!aresetn) begin
            sda_sync_r <= 3'h7;
            scl_sync_r <= 3'h7;
            sda_f_r    <= 1'b1;
            scl_f_r    <= 1'b1;
            sda_prev_r <= 1'b1;
        end else begin
            sda_sync_r <= {sda_sync_r[1:0], sda_i};
            scl_sync_r <= {scl_sync_r[1:0], scl_i};
            if (sda_sync_r[1] == sda_sync_r[2])
                sda_f_r <= sda_sync_r[2];
            if (scl_sync_r[1] == scl_sync_r[2])
                scl_f_r <= scl_sync_r[2];
            sda_prev_r <= sda_f_r;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `IBC_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `IBC_RESP_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
            sda_o         <= 1'b0;
            scl_o         <= 1'b0;
            sda_oe        <= 1'b0;
            scl_oe        <= 1'b0;
            irq           <= 1'b0;
            state_r       <= S_IDLE;
            brg_r         <= 7'h00;
            rate_r        <= `IBC_RATE_RST;
            ctrl_r        <= 5'h00;
            shift_r       <= 9'h000;
            bits_r        <= 4'h0;
            ack_mode_r    <= 1'b0;
            full_r        <= 1'b0;
            ackstat_r     <= 1'b0;
            start_seen_r  <= 1'b0;
            stop_seen_r   <= 1'b0;
            flags_r       <= 2'h0;
            mask_r        <= 2'h0;
        end else begin
            s_axi_awready <= wr_go;
            s_axi_wready  <= wr_go;
            s_axi_arready <= rd_go;
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_map ? `IBC_RESP_OKAY : `IBC_RESP_SLVERR;
            end else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `IBC_RESP_OKAY;
                case (s_axi_araddr)
                    `IBC_OFS_CTRL:     s_axi_rdata <= {27'h0, ctrl_r};
                    `IBC_OFS_STATUS:   s_axi_rdata <= {27'h0, !idle,
                        stop_seen_r, start_seen_r, ackstat_r, full_r};
                    `IBC_OFS_RATE:     s_axi_rdata <= {25'h0, rate_r};
                    `IBC_OFS_BUFFER:   s_axi_rdata <= {24'h0, shift_r[8:1]};
                    `IBC_OFS_IRQ_STAT: s_axi_rdata <= {30'h0, flags_r};
                    `IBC_OFS_IRQ_MASK: s_axi_rdata <= {30'h0, mask_r};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `IBC_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;

            // Software writes first so that hardware sets below win
            if (wr_lo) begin
                case (s_axi_awaddr)
                    `IBC_OFS_CTRL:     if (idle) ctrl_r <= s_axi_wdata[4:0];
                    `IBC_OFS_RATE:     rate_r <= s_axi_wdata[6:0];
                    `IBC_OFS_IRQ_STAT:
                        flags_r <= flags_r & ~s_axi_wdata[1:0];
                    `IBC_OFS_IRQ_MASK: mask_r <= s_axi_wdata[1:0];
                    `IBC_OFS_BUFFER:
                        if (idle) begin
                            // Always restarts at the first data bit
                            shift_r    <= {s_axi_wdata[7:0], 1'b1};
                            bits_r     <= 4'h9;
                            ack_mode_r <= 1'b0;
                            full_r     <= 1'b1;
                            state_r    <= S_BLOW;
                            brg_r      <= rate_r;
                            scl_oe     <= 1'b1;
                        end
                    default: ;
                endcase
            end

            // Bus watcher keeps running through and after a collision
            if (scl_f_r && sda_prev_r && !sda_f_r) begin
                start_seen_r <= 1'b1;
                stop_seen_r  <= 1'b0;
            end
            if (scl_f_r && !sda_prev_r && sda_f_r) begin
                start_seen_r <= 1'b0;
                stop_seen_r  <= 1'b1;
                flags_r[`IBC_IRQ_PORT] <= 1'b1;
            end

            if (!brg_end)
                brg_r <= brg_r - 7'h01;

            case (state_r)
                S_IDLE: begin
                    if (ctrl_r[`IBC_CTRL_START]) begin
                        if (!sda_f_r || !scl_f_r)
                            state_r <= S_IDLE;
                        else begin
                            state_r <= S_STC1;
                            brg_r   <= rate_r;
                        end
                    end else if (ctrl_r[`IBC_CTRL_RSTART]) begin
                        sda_oe  <= 1'b0;
                        state_r <= S_RSDA;
                    end else if (ctrl_r[`IBC_CTRL_STOP]) begin
                        sda_oe  <= 1'b1;
                        state_r <= S_SPLO;
                    end else if (ctrl_r[`IBC_CTRL_ACK]) begin
                        shift_r    <= {ctrl_r[`IBC_CTRL_ACKDT], 8'h00};
                        bits_r     <= 4'h1;
                        ack_mode_r <= 1'b1;
                        scl_oe     <= 1'b1;
                        brg_r      <= rate_r;
                        state_r    <= S_BLOW;
                    end
                end
                S_STC1: begin
                    if (!sda_f_r || brg_end) begin
                        sda_oe  <= 1'b1;
                        brg_r   <= rate_r;
                        state_r <= S_STC2;
                    end
                end
                S_STC2: begin
                    // SCL is not checked here: the other master lost first
                    if (brg_end) begin
                        scl_oe  <= 1'b1;
                        ctrl_r[`IBC_CTRL_START] <= 1'b0;
                        flags_r[`IBC_IRQ_PORT]  <= 1'b1;
                        state_r <= S_IDLE;
                    end
                end
                S_RSDA: begin
                    if (sda_f_r) begin
                        brg_r   <= rate_r;
                        state_r <= S_RSC1;
                    end
                end
                S_RSC1: begin
                    if (brg_end) begin
                        scl_oe  <= 1'b0;
                        state_r <= S_RSCW;
                    end
                end
                S_RSCW: begin
                    if (scl_f_r && sda_f_r) begin
                        brg_r   <= rate_r;
                        state_r <= S_RSC2;
                    end
                end
                S_RSC2: begin
                    if (brg_end) begin
                        sda_oe  <= 1'b1;
                        brg_r   <= rate_r;
                        state_r <= S_RSC3;
                    end
                end
                S_RSC3: begin
                    if (brg_end) begin
                        scl_oe  <= 1'b1;
                        ctrl_r[`IBC_CTRL_RSTART] <= 1'b0;
                        flags_r[`IBC_IRQ_PORT]   <= 1'b1;
                        state_r <= S_IDLE;
                    end
                end
                S_SPLO: begin
                    if (!sda_f_r) begin
                        scl_oe  <= 1'b0;
                        state_r <= S_SPCW;
                    end
                end
                S_SPCW: begin
                    if (scl_f_r) begin
                        brg_r   <= rate_r;
                        state_r <= S_SPC1;
                    end
                end
                S_SPC1: begin
                    if (brg_end) begin
                        sda_oe  <= 1'b0;
                        brg_r   <= rate_r;
                        state_r <= S_SPC2;
                    end
                end
                S_SPC2: begin
                    // Lets the released SDA settle through the filter first
                    if (brg_end) begin
                        ctrl_r[`IBC_CTRL_STOP] <= 1'b0;
                        flags_r[`IBC_IRQ_PORT] <= 1'b1;
                        state_r <= S_IDLE;
                    end
                end
                S_BLOW: begin
                    sda_oe <= !shift_r[8];
                    if (brg_end) begin
                        scl_oe  <= 1'b0;
                        state_r <= S_BSCW;
                    end
                end
                S_BSCW: begin
                    if (scl_f_r) begin
                        brg_r   <= rate_r;
                        state_r <= S_BHIG;
                    end
                end
                S_BHIG: begin
                    if (brg_end) begin
                        scl_oe <= 1'b1;
                        if (bits_r == 4'h1) begin
                            if (!ack_mode_r)
                                ackstat_r <= sda_f_r;
                            full_r  <= 1'b0;
                            sda_oe  <= 1'b0;
                            ctrl_r[`IBC_CTRL_ACK]  <= 1'b0;
                            flags_r[`IBC_IRQ_PORT] <= 1'b1;
                            state_r <= S_IDLE;
                        end else begin
                            shift_r <= {shift_r[7:0], 1'b0};
                            bits_r  <= bits_r - 4'h1;
                            brg_r   <= rate_r;
                            state_r <= S_BLOW;
                        end
                    end
                end
                default: state_r <= S_IDLE;
            endcase

            // Arbitration loss overrides whatever the sequencer chose
            if ((idle && ctrl_r[`IBC_CTRL_START] &&
                    (!sda_f_r || !scl_f_r)) ||
                (state_r == S_STC1 && sda_f_r && !scl_f_r) ||
                (state_r == S_RSCW && scl_f_r && !sda_f_r) ||
                (state_r == S_RSC2 && !scl_f_r && !sda_oe) ||
                (state_r == S_SPC1 && !scl_f_r) ||
                (state_r == S_SPC2 && brg_end && !sda_f_r) ||
                (state_r == S_BHIG && chk_one && !sda_f_r)) begin
                state_r <= S_IDLE;
                sda_oe  <= 1'b0;
                scl_oe  <= 1'b0;
                full_r  <= 1'b0;
                ctrl_r[3:0] <= 4'h0;
                flags_r[`IBC_IRQ_COLL] <= 1'b1;
            end

            irq <= |(flags_r & mask_r);
        end
    end

endmodule // ibc_bus_collision

// ---- tb/ibc_bus_collision_assertions.sv ----
// Checker for the AXI4-Lite handshake, open-drain pins and interrupt output
`timescale 1ns/1ps
module ibc_bus_collision_assertions (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awready,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire        sda_o,
    input wire        scl_o,
    input wire        irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_b_wait; s_axi_bvalid && !s_axi_bready; endsequence
    sequence s_r_wait; s_axi_rvalid && !s_axi_rready; endsequence
    property p_aw_w_pair; s_axi_awready |-> s_axi_wready; endproperty
    a_aw_w_pair: assert property (p_aw_w_pair)
        else $error("awready without wready");
    property p_aw_pulse; s_axi_awready |=> !s_axi_awready; endproperty
    a_aw_pulse: assert property (p_aw_pulse)
        else $error("awready longer than one cycle");
    property p_aw_resp; $rose(s_axi_awready) |-> s_axi_bvalid; endproperty
    a_aw_resp: assert property (p_aw_resp)
        else $error("write taken without response");
    property p_b_hold; s_b_wait |=> s_axi_bvalid; endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("bvalid dropped before bready");
    property p_ar_resp; s_axi_arready |-> s_axi_rvalid; endproperty
    a_ar_resp: assert property (p_ar_resp)
        else $error("read taken without data");
    property p_r_hold; s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read data changed before rready");
    // Open drain: a pin may only ever be pulled low, never driven high
    property p_lines_low; !sda_o && !scl_o; endproperty
    a_lines_low: assert property (p_lines_low)
        else $error("line output driven high");
    property p_irq_sticky;
        $fell(irq) |-> $past(s_axi_awready) || $past(s_axi_awready, 2);
    endproperty
    a_irq_sticky: assert property (p_irq_sticky)
        else $error("interrupt dropped without a register write");
endmodule // ibc_bus_collision_assertions

// ---- tb/ibc_rival.sv ----
// Pull-ups, a rival master and a bit recorder on the two-wire bus
`timescale 1ns/1ps
module ibc_rival (
    input  wire       aclk,
    input  wire       sda_oe,
    input  wire       scl_oe,
    input  wire       sda_hold,
    input  wire       steal,
    output wire       sda,
    output wire       scl,
    output reg  [8:0] rx_bits
);
    reg               scl_r;
    assign scl = ~scl_oe;
    // Rival pulls a released SDA low only while SCL is high
    assign sda = ~(sda_oe | sda_hold | (steal & scl & ~sda_oe));
    always @(posedge aclk) begin
        scl_r <= scl;
        if (scl & ~scl_r) begin
            rx_bits <= {rx_bits[7:0], sda};
        end
    end
endmodule // ibc_rival

// ---- tb/ibc_bus_collision_tb.sv ----
// Self-checking bench for the collision-aware two-wire master
`timescale 1ns/1ps
`include "ibc_map.vh"
module ibc_bus_collision_tb;
    reg         aclk = 0, aresetn = 0, sda_hold = 0, steal = 0;
    reg         awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    reg  [7:0]  awaddr = 0, araddr = 0;
    reg  [31:0] wdata = 0, rv;
    reg  [1:0]  rsp;
    wire        awready, wready, bvalid, arready, rvalid;
    wire        sda_o, sda_oe, scl_o, scl_oe, irq, sda, scl;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    wire [8:0]  rx_bits;
    integer     bad_count = 0, n_compared = 0, cyc = 0;
    always #12.5 aclk = ~aclk;
    ibc_bus_collision DUT (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .irq(irq));
    ibc_rival u_rival (.aclk(aclk), .sda_oe(sda_oe), .scl_oe(scl_oe),
        .sda_hold(sda_hold), .steal(steal), .sda(sda), .scl(scl),
        .rx_bits(rx_bits));
    task end_sim;
        begin
            if (bad_count == 0 && n_compared > 0) begin
                $display("SIMULATION PASSED");
            end else begin
                $display("SIMULATION FAILED");
            end
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] exp, input [31:0] got);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("Error %s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    // Each task is entered just after a rising edge
    task axw(input [7:0] a, input [31:0] d);
        begin
            awaddr <= a;
            wdata <= d;
            awvalid <= 1;
            wvalid <= 1;
            bready <= 1;
            do @(posedge aclk); while (awready !== 1'b1);
            awvalid <= 0;
            wvalid <= 0;
            while (bvalid !== 1'b1) @(posedge aclk);
            rsp = bresp;
            bready <= 0;
            @(posedge aclk);
        end
    endtask
    task axr(input [7:0] a);
        begin
            araddr <= a;
            arvalid <= 1;
            rready <= 1;
            do @(posedge aclk); while (arready !== 1'b1);
            arvalid <= 0;
            while (rvalid !== 1'b1) @(posedge aclk);
            rv = rdata;
            rsp = rresp;
            rready <= 0;
            @(posedge aclk);
        end
    endtask
    // Busy is polled, not timed: the rate reload sets the bit period
    task wait_idle;
        integer k;
        begin
            k = 0;
            rv = 32'h0000_0010;
            while (rv[4] !== 1'b0 && k < 200) begin
                axr(`IBC_OFS_STATUS);
                k = k + 1;
            end
            // A sequencer that never returns to idle counts as a mismatch
            if (k >= 200) begin
                bad_count = bad_count + 1;
                $display("Error busy expected 0 seen 1");
            end
        end
    endtask
    task t_regs;
        begin
            axr(`IBC_OFS_RATE);
            chk("rate reset", 32'h0000_0009, rv);
            axr(8'h40);
            chk("unmapped read resp", 32'h0000_0002, {30'h0, rsp});
            axw(8'h44, 32'h0000_0001);
            chk("unmapped write resp", 32'h0000_0002, {30'h0, rsp});
        end
    endtask
    task t_start_low;
        begin
            sda_hold <= 1;
            axw(`IBC_OFS_IRQ_MASK, 32'h0000_0000);
            repeat (4) @(posedge aclk);
            axw(`IBC_OFS_CTRL, 32'h0000_0001);
            wait_idle;
            axr(`IBC_OFS_CTRL);
            chk("ctrl after start", 32'h0000_0000, rv & 32'h0000_000F);
            axr(`IBC_OFS_IRQ_STAT);
            chk("collision flag", 32'h0000_0001, rv & 32'h0000_0001);
            chk("irq masked", 32'h0000_0000, irq);
            axw(`IBC_OFS_IRQ_MASK, 32'h0000_0001);
            chk("irq unmasked", 32'h0000_0001, irq);
            axw(`IBC_OFS_IRQ_STAT, 32'h0000_0001);
            chk("irq cleared", 32'h0000_0000, irq);
            sda_hold <= 0;
            repeat (8) @(posedge aclk);
        end
    endtask
    task t_byte_coll;
        begin
            axw(`IBC_OFS_CTRL, 32'h0000_0001);
            wait_idle;
            steal <= 1;
            axw(`IBC_OFS_BUFFER, 32'h0000_00FF);
            wait_idle;
            chk("full and busy", 32'h0000_0000, rv & 32'h0000_0011);
            chk("line drive", 32'h0000_0000, {sda_oe, scl_oe});
            chk("irq on collision", 32'h0000_0001, irq);
            axw(`IBC_OFS_IRQ_STAT, 32'h0000_0003);
            steal <= 0;
            repeat (8) @(posedge aclk);
            axr(`IBC_OFS_IRQ_STAT);
            chk("port flag on stop", 32'h0000_0002, rv);
            axr(`IBC_OFS_STATUS);
            chk("stop seen", 32'h0000_0008, rv & 32'h0000_000C);
        end
    endtask
    task t_resume;
        begin
            axw(`IBC_OFS_IRQ_STAT, 32'h0000_0003);
            axw(`IBC_OFS_CTRL, 32'h0000_0001);
            wait_idle;
            axw(`IBC_OFS_BUFFER, 32'h0000_0055);
            wait_idle;
            chk("bits on wire", 32'h0000_0055, rx_bits[8:1]);
            chk("nack seen", 32'h0000_0002, rv & 32'h0000_0002);
        end
    endtask
    task t_stop_coll;
        begin
            sda_hold <= 1;
            axw(`IBC_OFS_IRQ_STAT, 32'h0000_0003);
            axw(`IBC_OFS_CTRL, 32'h0000_0004);
            wait_idle;
            axr(`IBC_OFS_CTRL);
            chk("ctrl after stop", 32'h0000_0000, rv & 32'h0000_000F);
            axr(`IBC_OFS_IRQ_STAT);
            chk("stop collision", 32'h0000_0001, rv & 32'h0000_0001);
            chk("line drive", 32'h0000_0000, {sda_oe, scl_oe});
            sda_hold <= 0;
            repeat (8) @(posedge aclk);
        end
    endtask
    // Rival drives a zero once SCL is released in the repeated start
    task t_rstart_coll;
        begin
            axw(`IBC_OFS_IRQ_STAT, 32'h0000_0003);
            axw(`IBC_OFS_CTRL, 32'h0000_0001);
            wait_idle;
            steal <= 1;
            axw(`IBC_OFS_CTRL, 32'h0000_0002);
            wait_idle;
            axr(`IBC_OFS_CTRL);
            chk("ctrl after rstart", 32'h0000_0000, rv & 32'h0000_000F);
            axr(`IBC_OFS_IRQ_STAT);
            chk("rstart collision", 32'h0000_0001, rv & 32'h0000_0001);
            chk("line drive", 32'h0000_0000, {sda_oe, scl_oe});
            steal <= 0;
            repeat (8) @(posedge aclk);
        end
    endtask
    // Longest run is a few hundred cycles; the ceiling leaves margin
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            bad_count = bad_count + 1;
            end_sim;
        end
    end
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        t_regs;
        t_start_low;
        t_byte_coll;
        t_resume;
        t_stop_coll;
        t_rstart_coll;
        end_sim;
    end
endmodule // ibc_bus_collision_tb
bind ibc_bus_collision ibc_bus_collision_assertions u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .sda_o(sda_o), .scl_o(scl_o), .irq(irq));
